// ===== rtl/ccs_top.sv
// Clock source decode, start-up timing and clock domain gating.
// Assumes oscillator ticks and fuse levels arrive from outside sys_clk and are synchronised here.
`include "ccs_map.svh"
module ccs_top
	import ccs_pkg::*;
#(
	parameter int WDT_SHORT = 4096,
	parameter int WDT_LONG  = 65536
)(
	// Clock, reset, freeze
	input  wire logic        sys_clk,
	input  wire logic        rst,
	input  wire logic        clk_en,
	// Fuse levels
	input  wire logic [3:0]  fuse_clock_source_select,
	input  wire logic [1:0]  fuse_startup_time_select,
	input  wire logic        fuse_oscillator_amplifier_option,
	// Oscillator ticks and asynchronous wake sources
	input  wire logic        src_osc_tick,
	input  wire logic        wdt_osc_tick,
	input  wire logic        async_xtal_tick,
	input  wire logic        ext_int_async,
	input  wire logic        two_wire_iface_addr_match,
	// Avalon-MM slave
	input  wire logic [3:0]  avs_address,
	input  wire logic        avs_read,
	input  wire logic        avs_write,
	input  wire logic [31:0] avs_writedata,
	input  wire logic [3:0]  avs_byteenable,
	output logic      [31:0] avs_readdata,
	output logic             avs_waitrequest,
	// Clock domain enables
	output logic             core_clock_en,
	output logic             peripheral_clock_en,
	output logic             nvm_interface_clock_en,
	output logic             async_timer_clock_en,
	output logic             converter_clock_en
);

	// Refuse delays the counter cannot hold
	// The shared counter is 17 bits wide, so the long delay must fit in it
	// and the short delay may not exceed the long one
	if (WDT_SHORT < 1 || WDT_LONG < WDT_SHORT || WDT_LONG > 131071)
	begin : g_chk
		$error("ccs_top: watchdog delay counts out of range");
	end

	ccs_regs_t   r;        // All state
	ccs_regs_t   nx;       // Next state
	ccs_pin_t    rise;     // Tick edges
	ccs_pin_t    pins;     // Raw pin bundle
	ccs_fuse_t   fpins;    // Raw fuse bundle
	ccs_src_t    src;      // Decoded source
	ccs_band_t   band;     // Crystal band
	ccs_dly_t    dly;      // Reset delay option
	logic [16:0] src_need; // Source cycles to count
	logic [16:0] dly_need; // Watchdog cycles to count
	logic        wake_ev;  // Asynchronous wake request
	logic        req;      // Bus request present
	logic        acc;      // Bus request accepted this cycle
	logic [31:0] rd_mux;   // Read data selection

	assign pins  = '{src: src_osc_tick, wdt: wdt_osc_tick, asy: async_xtal_tick,
		ext: ext_int_async, two_wire_iface: two_wire_iface_addr_match};
	assign fpins = '{src_sel: fuse_clock_source_select, sut: fuse_startup_time_select,
		amp_opt: fuse_oscillator_amplifier_option};

	// Domain enables for each sleep mode
	// The async timer domain stays on in every sleep so the real-time count survives
	// The nonvolatile interface clock always follows the core clock
	function automatic ccs_gate_t gate_for(input ccs_sleep_t m);
		ccs_gate_t g;
		g = '{core: 1'b0, periph: 1'b0, nvm: 1'b0, asy: 1'b1, conv: 1'b0};
		case (m)
			CCS_SLP_IDLE:  // Core halted, peripherals and converter run
			begin
				g.periph = 1'b1;
				g.conv   = 1'b1;
			end
			CCS_SLP_ADCNR: g.conv = 1'b1; // Quiet converter domain
			default:       g.conv = 1'b0; // Deep sleep: only the async timer
		endcase
		return g;
	endfunction

	// Source decode, programmed bit reads zero
	// Code ranges are contiguous, so ordered compares pick the group
	always_comb
	begin
		if (r.fuse.src_sel >= 4'hA) src = CCS_SRC_XTAL;
		else if (r.fuse.src_sel == 4'h9) src = CCS_SRC_LFXTAL;
		else if (r.fuse.src_sel >= 4'h5) src = CCS_SRC_EXTRC;
		else if (r.fuse.src_sel >= 4'h1) src = CCS_SRC_INTRC;
		else src = CCS_SRC_EXTCLK;
	end

	// Crystal band, programmed amplifier option widens it
	always_comb
	begin
		if (!r.fuse.amp_opt) band = CCS_BAND_WIDE;
		else
		begin
			case (r.fuse.src_sel[3:1])
				3'h5:    band = CCS_BAND_LOW;
				3'h6:    band = CCS_BAND_MID;
				default: band = CCS_BAND_HIGH;
			endcase
		end
	end

	// Start-up counts per source and start-up select
	// Defaults keep the shortest count so no path leaves the count unset
	// Reserved start-up codes fall back to the nearest legal option
	always_comb
	begin
		src_need = `CCS_CK_6;
		dly      = CCS_DLY_NONE;
		case (src)
			CCS_SRC_XTAL:
			begin
				if (!r.fuse.src_sel[0])
				begin
					src_need = r.fuse.sut[1] ? `CCS_CK_1K : `CCS_CK_258;
					case (r.fuse.sut)
						2'h0:    dly = CCS_DLY_SHORT;
						2'h1:    dly = CCS_DLY_LONG;
						2'h2:    dly = CCS_DLY_NONE;
						default: dly = CCS_DLY_SHORT;
					endcase
				end
				else
				begin
					src_need = (r.fuse.sut == 2'h0) ? `CCS_CK_1K : `CCS_CK_16K;
					case (r.fuse.sut)
						2'h0:    dly = CCS_DLY_LONG;
						2'h1:    dly = CCS_DLY_NONE;
						2'h2:    dly = CCS_DLY_SHORT;
						default: dly = CCS_DLY_LONG;
					endcase
				end
			end
			CCS_SRC_LFXTAL:
			begin
				src_need = (r.fuse.sut == 2'h2) ? `CCS_CK_32K : `CCS_CK_1K;
				dly      = (r.fuse.sut == 2'h0) ? CCS_DLY_SHORT : CCS_DLY_LONG;
			end
			CCS_SRC_EXTRC:
			begin
				src_need = (r.fuse.sut == 2'h3) ? `CCS_CK_6 : `CCS_CK_18;
				case (r.fuse.sut)
					2'h0:    dly = CCS_DLY_NONE;
					2'h2:    dly = CCS_DLY_LONG;
					default: dly = CCS_DLY_SHORT;
				endcase
			end
			default: // Internal RC and external clock
			begin
				case (r.fuse.sut)
					2'h0:    dly = CCS_DLY_NONE;
					2'h1:    dly = CCS_DLY_SHORT;
					default: dly = CCS_DLY_LONG;
				endcase
			end
		endcase
		dly_need = (dly == CCS_DLY_LONG) ? 17'(WDT_LONG) : 17'(WDT_SHORT);
	end

	// Edges, wake sources and bus handshake
	// Logic reads only the second and third stages, never the first flop
	// With the clock enable high, every request gets exactly one wait cycle before it is accepted
	assign rise    = ccs_pin_t'(r.s2 & ~r.s3);
	assign wake_ev = r.s2.ext | r.s2.two_wire_iface; // Asynchronous sources wake any sleep
	assign req     = avs_read | avs_write;
	assign acc     = req & ~r.waitrequest;

	// Register read selection; unmapped offsets read zero
	always_comb
	begin
		case (avs_address)
			`CCS_OFF_CTRL:   rd_mux = {29'h0, r.sleep_mode, 1'b0};
			`CCS_OFF_STATUS: rd_mux = {23'h0, r.wake_flag, band, src, r.state};
			`CCS_OFF_FUSE:   rd_mux = {25'h0, r.fuse};
			`CCS_OFF_RTC:    rd_mux = {16'h0, r.rtc};
			default:         rd_mux = 32'h0;
		endcase
	end

	// Next state
	// Synchroniser stages shift on every enabled edge, in every state
	always_comb
	begin
		nx    = r;
		nx.s1 = pins;
		nx.s2 = r.s1;
		nx.s3 = r.s2;
		nx.f1 = fpins;
		nx.f2 = r.f1;
		// Real-time counter keeps running in every state
		if (rise.asy) nx.rtc = r.rtc + 16'h0001;
		// Bus: one wait cycle, then accept
		nx.waitrequest = ~(req & r.waitrequest);
		if (req & r.waitrequest) nx.readdata = rd_mux;
		if (acc && avs_write && avs_byteenable[0])
		begin
			if (avs_address == `CCS_OFF_CTRL)
				nx.sleep_mode = ccs_sleep_t'(avs_writedata[`CCS_CTRL_MODE]);
			if (avs_address == `CCS_OFF_STATUS && avs_writedata[`CCS_STAT_WAKE])
				nx.wake_flag = 1'b0;
		end
		case (r.state)
			CCS_ST_CAPTURE: // Let the fuse synchroniser fill, then latch
			begin
				nx.cap_cnt = r.cap_cnt + 2'h1;
				if (r.cap_cnt == `CCS_CAP_LAST)
				begin
					nx.fuse  = r.f2;
					nx.cnt   = 17'h0;
					nx.state = CCS_ST_SRC;
				end
			end
			CCS_ST_SRC: // Source cycles, then any reset delay
			begin
				if (rise.src) nx.cnt = r.cnt + 17'h1;
				if (r.cnt >= src_need)
				begin
					nx.cnt = 17'h0;
					if (dly == CCS_DLY_NONE)
					begin
						nx.state = CCS_ST_RUN;
						nx.gate  = '{core: 1'b1, periph: 1'b1, nvm: 1'b1, asy: 1'b1, conv: 1'b1};
					end
					else nx.state = CCS_ST_RSTDLY;
				end
			end
			CCS_ST_RSTDLY: // Watchdog-timed delay after reset
			begin
				if (rise.wdt) nx.cnt = r.cnt + 17'h1;
				if (r.cnt >= dly_need)
				begin
					nx.state = CCS_ST_RUN;
					nx.gate  = '{core: 1'b1, periph: 1'b1, nvm: 1'b1, asy: 1'b1, conv: 1'b1};
				end
			end
			CCS_ST_RUN: // Software enters sleep by the go bit
			begin
				if (acc && avs_write && avs_byteenable[0] && avs_address == `CCS_OFF_CTRL
					&& avs_writedata[`CCS_CTRL_GO])
				begin
					nx.state = CCS_ST_SLEEP;
					nx.gate  = gate_for(ccs_sleep_t'(avs_writedata[`CCS_CTRL_MODE]));
				end
			end
			CCS_ST_SLEEP:
			begin
				if (wake_ev)
				begin
					nx.wake_flag = 1'b1; // Set wins over a clear in the same cycle
					nx.cnt       = 17'h0;
					if (r.sleep_mode == CCS_SLP_PDOWN || r.sleep_mode == CCS_SLP_PSAVE)
						nx.state = CCS_ST_WAKE; // Oscillator restarts: time it
					else
					begin
						nx.state = CCS_ST_RUN;
						nx.gate  = '{core: 1'b1, periph: 1'b1, nvm: 1'b1, asy: 1'b1, conv: 1'b1};
					end
				end
			end
			CCS_ST_WAKE: // Source cycles before execution resumes
			begin
				if (rise.src) nx.cnt = r.cnt + 17'h1;
				if (r.cnt >= src_need)
				begin
					nx.state = CCS_ST_RUN;
					nx.gate  = '{core: 1'b1, periph: 1'b1, nvm: 1'b1, asy: 1'b1, conv: 1'b1};
				end
			end
			default: nx.state = CCS_ST_CAPTURE;
		endcase
	end

	// State register; shipped fuse values until the first capture
	// A low clock enable freezes the bus handshake too, so a request just waits
	always_ff @(posedge sys_clk)
	begin
		if (rst)
		begin
			r             <= '0;
			r.state       <= CCS_ST_CAPTURE;
			r.fuse        <= '{src_sel: `CCS_FUSE_SRC_RST, sut: `CCS_FUSE_SUT_RST, amp_opt: `CCS_FUSE_OPT_RST};
			r.sleep_mode  <= CCS_SLP_IDLE;
			r.waitrequest <= 1'b1;
		end
		else if (clk_en) r <= nx;
	end

	// Outputs straight from flops
	assign avs_readdata           = r.readdata;
	assign avs_waitrequest        = r.waitrequest;
	assign core_clock_en          = r.gate.core;
	assign peripheral_clock_en    = r.gate.periph;
	assign nvm_interface_clock_en = r.gate.nvm;
	assign async_timer_clock_en   = r.gate.asy;
	assign converter_clock_en     = r.gate.conv;

	// Checks
	// All checks share sys_clk and are quiet while reset is held
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (rst);

	AST_NVM_WITH_CORE: assert property (nvm_interface_clock_en == core_clock_en)
		else $error("nvm clock differs from core clock");
	AST_GATED_UNTIL_RUN: assert property (r.state != CCS_ST_RUN |-> !core_clock_en)
		else $error("core clock on before start-up done");
	AST_CONV_QUIET: assert property ((r.state == CCS_ST_SLEEP && !core_clock_en && converter_clock_en)
		|-> !peripheral_clock_en || r.sleep_mode == CCS_SLP_IDLE)
		else $error("converter sleep gating wrong");
	AST_RTC_COUNTS: assert property (clk_en && rise.asy |=> r.rtc == $past(r.rtc) + 16'h0001)
		else $error("async timer missed a tick");
	AST_DEEP_WAKE_TIMED: assert property ((clk_en && r.state == CCS_ST_SLEEP && wake_ev
		&& r.sleep_mode[1]) |=> r.state == CCS_ST_WAKE ##1 !core_clock_en)
		else $error("deep wake skipped start-up count");
	AST_EXTCLK_DECODE: assert property (r.fuse.src_sel == 4'h0 |-> src == CCS_SRC_EXTCLK)
		else $error("external clock decode wrong");
	AST_SHIPPED: assert property ($fell(rst) |-> r.fuse.src_sel == 4'h1 && r.fuse.sut == 2'h2)
		else $error("shipped fuse value wrong");
	AST_LONG_DELAY: assert property (r.state == CCS_ST_RSTDLY && dly == CCS_DLY_LONG
		|-> dly_need == 17'(WDT_LONG))
		else $error("long reset delay count wrong");
	AST_WIDE_BAND: assert property (!r.fuse.amp_opt |-> band == CCS_BAND_WIDE)
		else $error("programmed amplifier band wrong");
	AST_XTAL_258: assert property (src == CCS_SRC_XTAL && !r.fuse.src_sel[0] && !r.fuse.sut[1]
		|-> src_need == 17'h00102)
		else $error("258-cycle start-up wrong");
	AST_XTAL_16K: assert property (src == CCS_SRC_XTAL && r.fuse.src_sel[0] && r.fuse.sut != 2'h0
		|-> src_need == 17'h04000)
		else $error("16K start-up wrong");
	AST_ASYNC_WAKE: assert property (clk_en && r.state == CCS_ST_SLEEP && r.s2.two_wire_iface
		|=> r.state != CCS_ST_SLEEP && r.wake_flag)
		else $error("address match did not wake");
	AST_IDLE_PERIPH: assert property (r.state == CCS_ST_SLEEP && r.sleep_mode == CCS_SLP_IDLE
		&& !core_clock_en |-> peripheral_clock_en)
		else $error("peripheral clock off in idle");
endmodule

// ===== rtl/ccs_map.svh
// Offsets, field positions, reset values and start-up counts of the clock control block.
// Assumes the includer uses these with the types of ccs_pkg.
// What this block does
// - Decode four fuse bits into five clock sources.
// - Fuse bit one means unprogrammed, zero programmed.
// - Count source cycles on wake from deep sleep.
// - Reset adds none, 4096 or 65536 watchdog cycles.
// - Shipped fuses 0001 and 10: internal RC.
// - Gate unused domains per sleep; core gate halts.
// - Peripheral clock feeds timers; some interrupts asynchronous.
// - Two-wire address match wakes from any sleep.
// - Nonvolatile interface clock follows core clock.
// - Async timer counts its crystal during sleep.
// - Converter clock runs while core, peripherals gated.
// - Crystal band from bits three to one.
// - Bit zero clear: 258/1K cycles, listed delays.
// - Bit zero set: 1K+65ms, else 16K cycles.
`ifndef CCS_MAP_SVH
`define CCS_MAP_SVH
// Register byte offsets
`define CCS_OFF_CTRL   4'h0
`define CCS_OFF_STATUS 4'h4
`define CCS_OFF_FUSE   4'h8
`define CCS_OFF_RTC    4'hC
// Control fields
`define CCS_CTRL_GO    0
`define CCS_CTRL_MODE  2:1
// Status write-one-to-clear wake flag
`define CCS_STAT_WAKE  8
// Shipped fuse values
`define CCS_FUSE_SRC_RST 4'h1
`define CCS_FUSE_SUT_RST 2'h2
`define CCS_FUSE_OPT_RST 1'h1
// Start-up counts in source cycles
`define CCS_CK_6   17'h00006
`define CCS_CK_18  17'h00012
`define CCS_CK_258 17'h00102
`define CCS_CK_1K  17'h00400
`define CCS_CK_16K 17'h04000
`define CCS_CK_32K 17'h08000
// Reset delays in watchdog oscillator cycles
`define CCS_WDT_SHORT 17'h01000
`define CCS_WDT_LONG  17'h10000
// Last capture count while the fuse synchroniser fills
`define CCS_CAP_LAST  2'h3
`endif

// ===== rtl/ccs_pkg.sv
// Types of the clock control block.
// Assumes nothing beyond a SystemVerilog compiler.
package ccs_pkg;
	typedef enum logic [2:0] {
		CCS_ST_CAPTURE = 3'b000,
		CCS_ST_SRC     = 3'b001,
		CCS_ST_RSTDLY  = 3'b010,
		CCS_ST_RUN     = 3'b011,
		CCS_ST_SLEEP   = 3'b100,
		CCS_ST_WAKE    = 3'b101
	} ccs_state_t;
	typedef enum logic [2:0] {
		CCS_SRC_XTAL   = 3'b000,
		CCS_SRC_LFXTAL = 3'b001,
		CCS_SRC_EXTRC  = 3'b010,
		CCS_SRC_INTRC  = 3'b011,
		CCS_SRC_EXTCLK = 3'b100
	} ccs_src_t;
	typedef enum logic [1:0] {
		CCS_SLP_IDLE  = 2'b00,
		CCS_SLP_ADCNR = 2'b01,
		CCS_SLP_PDOWN = 2'b10,
		CCS_SLP_PSAVE = 2'b11
	} ccs_sleep_t;
	typedef enum logic [1:0] {
		CCS_DLY_NONE  = 2'b00,
		CCS_DLY_SHORT = 2'b01,
		CCS_DLY_LONG  = 2'b10
	} ccs_dly_t;
	typedef enum logic [1:0] {
		CCS_BAND_LOW  = 2'b00,
		CCS_BAND_MID  = 2'b01,
		CCS_BAND_HIGH = 2'b10,
		CCS_BAND_WIDE = 2'b11
	} ccs_band_t;
	typedef struct packed {
		logic [3:0] src_sel;
		logic [1:0] sut;
		logic       amp_opt;
	} ccs_fuse_t;
	typedef struct packed {
		logic src;
		logic wdt;
		logic asy;
		logic ext;
		logic two_wire_iface;
	} ccs_pin_t;
	typedef struct packed {
		logic core;
		logic periph;
		logic nvm;
		logic asy;
		logic conv;
	} ccs_gate_t;
	typedef struct packed {
		ccs_state_t  state;
		ccs_fuse_t   f1;
		ccs_fuse_t   f2;
		ccs_fuse_t   fuse;
		ccs_pin_t    s1;
		ccs_pin_t    s2;
		ccs_pin_t    s3;
		logic [1:0]  cap_cnt;
		logic [16:0] cnt;
		ccs_sleep_t  sleep_mode;
		ccs_gate_t   gate;
		logic        wake_flag;
		logic [15:0] rtc;
		logic        waitrequest;
		logic [31:0] readdata;
	} ccs_regs_t;
endpackage

// ===== sim/ccs_osc_model.sv
// Free-running oscillator sources at the far side of the clock control block.
// Assumes the bench wires the ticks to the block; phases are unrelated to sys_clk.
module ccs_osc_model #(
	parameter int SRC_HALF = 60,
	parameter int WDT_HALF = 1030,
	parameter int ASY_HALF = 710
)(
	// Oscillator outputs
	output logic src_osc_tick,
	output logic wdt_osc_tick,
	output logic async_xtal_tick
);
	timeunit 1ns;
	timeprecision 1ns;
	// Selected source is a slow ceramic resonator, so short start-up and low band are fair
	initial src_osc_tick = 1'b0;
	initial wdt_osc_tick = 1'b0;
	initial async_xtal_tick = 1'b0;
	// Each source toggles on its own half period
	always #(SRC_HALF) src_osc_tick = ~src_osc_tick;
	always #(WDT_HALF) wdt_osc_tick = ~wdt_osc_tick;
	always #(ASY_HALF) async_xtal_tick = ~async_xtal_tick;
endmodule

// ===== sim/tb_top.sv
// Self-checking bench of the clock control block.
// Assumes ccs_top with shortened watchdog counts and the oscillator model.
module tb_top;
	timeunit 1ns;
	timeprecision 1ns;
	localparam int WDT_S = 4;
	localparam int WDT_L = 8;
	// Decode table: source select, amplifier option, source, band
	localparam logic [9:0] DEC [10] = '{10'h3E2, 10'h321, 10'h2A0, 10'h2C3, 10'h264,
		10'h228, 10'h168, 10'h12C, 10'h06C, 10'h030};
	// Crystal cases: source select and start-up select, then counts
	localparam logic [5:0] CSEL [5] = '{6'h2A, 6'h28, 6'h2B, 6'h2C, 6'h2D};
	localparam int CNEED [5] = '{1024, 258, 1024, 1024, 16384};
	localparam int CWDT [5] = '{0, WDT_S, WDT_S, WDT_L, 0};
	// Gate pattern {core, periph, nvm, asy, conv} per sleep mode
	localparam logic [4:0] GATE [4] = '{5'h0B, 5'h03, 5'h02, 5'h02};
	// Stimulus
	logic        sys_clk  = 1'b0;
	logic        rst      = 1'b1;
	logic [3:0]  f_src    = 4'h1;
	logic [1:0]  f_sut    = 2'h2;
	logic        f_opt    = 1'b1;
	logic        ext_int  = 1'b0;
	logic        twi_hit  = 1'b0;
	logic        clk_en   = 1'b1;
	logic [3:0]  avs_address = 4'h0;
	logic        avs_read    = 1'b0;
	logic        avs_write   = 1'b0;
	logic [31:0] avs_writedata = 32'h0;
	// Observed
	logic [31:0] avs_readdata;
	logic        avs_waitrequest;
	logic [4:0]  gates;
	logic        src_tick;
	logic        wdt_tick;
	logic        asy_tick;
	logic [31:0] rdata;
	logic [31:0] r1;
	int          failures = 0;
	int          checked  = 0;
	int          src_cnt  = 0;
	int          wdt_cnt  = 0;
	int          need_now = 0;
	int          wait_n   = 0;

	always #25 sys_clk = ~sys_clk;
	// Source ticks, and watchdog ticks once the source count is reached
	always @(posedge src_tick) src_cnt++;
	always @(posedge wdt_tick) if (src_cnt >= need_now) wdt_cnt++;

	ccs_top #(.WDT_SHORT(WDT_S), .WDT_LONG(WDT_L)) i_dut (
		.sys_clk(sys_clk), .rst(rst), .clk_en(clk_en),
		.fuse_clock_source_select(f_src), .fuse_startup_time_select(f_sut),
		.fuse_oscillator_amplifier_option(f_opt),
		.src_osc_tick(src_tick), .wdt_osc_tick(wdt_tick), .async_xtal_tick(asy_tick),
		.ext_int_async(ext_int), .two_wire_iface_addr_match(twi_hit),
		.avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
		.avs_writedata(avs_writedata), .avs_byteenable(4'hF),
		.avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
		.core_clock_en(gates[4]), .peripheral_clock_en(gates[3]),
		.nvm_interface_clock_en(gates[2]), .async_timer_clock_en(gates[1]),
		.converter_clock_en(gates[0])
	);
	ccs_osc_model i_osc (.src_osc_tick(src_tick), .wdt_osc_tick(wdt_tick), .async_xtal_tick(asy_tick));

	// Compare and count
	task check(input logic [31:0] seen, input logic [31:0] exp);
		checked++;
		if (seen !== exp)
		begin
			failures++;
			$display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask

	// Verdict and end of run
	task results;
		if (failures == 0 && checked > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask

	// One Avalon-MM transfer; held until waitrequest is sampled low
	task bus(input logic wr, input logic [3:0] a, input logic [31:0] wd);
		int n;
		n = 0;
		avs_address <= a;
		avs_write <= wr;
		avs_read <= !wr;
		avs_writedata <= wd;
		@(posedge sys_clk);
		while (avs_waitrequest !== 1'b0 && n < 50)
		begin
			@(posedge sys_clk);
			n++;
		end
		rdata = avs_readdata;
		avs_read <= 1'b0;
		avs_write <= 1'b0;
		@(posedge sys_clk);
		check(32'(n < 50), 32'h1);
	endtask

	// Reset with given fuse levels; clocks stay gated throughout
	task do_reset(input logic [3:0] s, input logic [1:0] u, input logic o);
		f_src <= s;
		f_sut <= u;
		f_opt <= o;
		rst <= 1'b1;
		repeat (6) @(posedge sys_clk);
		check(32'(gates), 32'h0);
		rst <= 1'b0;
		src_cnt = 0;
		wdt_cnt = 0;
	endtask

	// Wait for the core clock under a bound
	task wait_run;
		wait_n = 0;
		while (gates[4] !== 1'b1 && wait_n < 60000)
		begin
			@(posedge sys_clk);
			wait_n++;
		end
		check(32'(wait_n < 60000), 32'h1);
	endtask

	// Source decode and crystal band for every code group
	task t_decode;
		for (int i = 0; i < 10; i++)
		begin
			do_reset(DEC[i][9:6], 2'h2, DEC[i][5]);
			repeat (8) @(posedge sys_clk);
			bus(1'b0, 4'h4, 32'h0);
			check(32'(rdata[5:3]), 32'(DEC[i][4:2]));
			if (DEC[i][4:2] == 3'h0)
				check(32'(rdata[7:6]), 32'(DEC[i][1:0]));
		end
	endtask

	// Crystal start-up counts and watchdog-timed reset delays
	task t_count;
		for (int i = 0; i < 5; i++)
		begin
			need_now = CNEED[i];
			do_reset(CSEL[i][5:2], CSEL[i][1:0], 1'b1);
			wait_run();
			check(32'(src_cnt >= CNEED[i]), 32'h1);
			check(32'(wdt_cnt >= CWDT[i] && wdt_cnt <= CWDT[i] + 2), 32'h1);
			if (CWDT[i] == 0)
				check(32'(src_cnt <= CNEED[i] + 5), 32'h1);
		end
	endtask

	// Shipped fuses, early sleep request, unmapped address, start-up
	task t_default;
		need_now = 6;
		do_reset(4'h1, 2'h2, 1'b1);
		bus(1'b1, 4'h0, 32'h1);
		bus(1'b0, 4'h8, 32'h0);
		check(rdata, 32'h0D);
		bus(1'b1, 4'h2, 32'hFF);
		bus(1'b0, 4'h2, 32'h0);
		check(rdata, 32'h0);
		wait_run();
		check(32'(wdt_cnt >= WDT_L), 32'h1);
		check(32'(gates), 32'h1F);
		bus(1'b0, 4'h4, 32'h0);
		check(rdata & 32'h3F, 32'h1B);
		clk_en <= 1'b0;
		repeat (20) @(posedge sys_clk);
		check(32'(gates), 32'h1F);
		check(32'(avs_waitrequest), 32'h1);
		clk_en <= 1'b1;
		@(posedge sys_clk);
	endtask

	// Every sleep mode: gating, timer during sleep, wake and wake flag
	task t_sleep;
		for (int m = 0; m < 4; m++)
		begin
			bus(1'b1, 4'h0, 32'(m * 2 + 1));
			repeat (2) @(posedge sys_clk);
			check(32'(gates), 32'(GATE[m]));
			bus(1'b0, 4'h0, 32'h0);
			check(rdata, 32'(m * 2));
			bus(1'b0, 4'hC, 32'h0);
			r1 = rdata;
			repeat (60) @(posedge sys_clk);
			bus(1'b0, 4'hC, 32'h0);
			check(32'(rdata !== r1), 32'h1);
			if (m < 2)
				ext_int <= 1'b1;
			else
				twi_hit <= 1'b1;
			src_cnt = 0;
			wait_run();
			if (m < 2)
				check(32'(wait_n <= 6), 32'h1);
			else
				check(32'(src_cnt >= 6), 32'h1);
			ext_int <= 1'b0;
			twi_hit <= 1'b0;
			bus(1'b0, 4'h4, 32'h0);
			check(rdata & 32'h107, 32'h103);
			bus(1'b1, 4'h4, 32'h100);
			bus(1'b0, 4'h4, 32'h0);
			check(32'(rdata[8]), 32'h0);
		end
	endtask

	// Main sequence
	initial
	begin
		@(posedge sys_clk);
		t_decode();
		t_count();
		t_default();
		t_sleep();
		results();
	end

	// Hang guard
	initial
	begin
		#4000000;
		failures++;
		results();
	end
endmodule
